// [lpp_pkg.sv]
`default_nettype none
package lpp_pkg;
  // ---------------------------------------------------------------
  // widths and register map
  // ---------------------------------------------------------------
  localparam int LPP_AW = 5;
  localparam int LPP_DW = 8;
  localparam int LPP_NREG = 32;
  localparam logic [4:0] LPP_OFF_STATUS = 5'h1D; // sticky events, read only
  localparam logic [4:0] LPP_OFF_IRQ_EN = 5'h1E; // enable mask
  localparam logic [4:0] LPP_OFF_CLEAR = 5'h1F;  // write one to clear
  localparam logic [7:0] LPP_RST_CTRL = 8'h00;
  // status bit positions
  localparam int LPP_EV_HOST_WR = 0;
  localparam int LPP_EV_HOST_RD = 1;
  localparam int LPP_EV_SW_WR = 2;
  localparam int LPP_NEV = 3;
  // bus flavours
  typedef enum logic [1:0] {
    LPP_FLV_SPLIT = 2'h1,
    LPP_FLV_DSTRB = 2'h2
  } lpp_flavour_t;
endpackage
`default_nettype wire

// [lpp_mem_if.sv]
`default_nettype none
interface lpp_mem_if;
  logic we;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic [4:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [lpp_regmem.sv]
`default_nettype none
module lpp_regmem
  import lpp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  lpp_mem_if.mem m
);
  logic [LPP_DW-1:0] mem_q [LPP_NREG];
  logic [LPP_DW-1:0] rdata_q;

  // control bits, all zero under reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < LPP_NREG; i++)
        mem_q[i] <= LPP_RST_CTRL;
    end
    else if (m.we)
      mem_q[m.waddr] <= m.wdata;
  end

  // registered read port
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      rdata_q <= 8'h00;
    else
      rdata_q <= mem_q[m.raddr];
  end
  assign m.rdata = rdata_q;
endmodule
`default_nettype wire

// [lpp_host_port.sv]
// Functional notes
// - parallel port works only while iface_sel_hi is low.
// - non-multiplexed mode takes address from the five address pins.
// - multiplexed mode latches address from data lines at strobe rising edge.
// - data lines carry data, or address then data when multiplexed.
// - chip select low needed; read, write and data strobes ignored while it is high (the address latch strobe is not).
// - hard reset low forces every control bit to zero.
// - interrupt pin pulled low while an enabled status event is set.
// - bus_flavour_select low: read/write strobes; high: data strobe and direction.
// - flavour high turns the three strobe pins into strobe, address strobe, direction.
// - read strobe and data strobe are active low.
`default_nettype none
module lpp_host_port
  import lpp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  // host pins
  input wire logic i_cs_n,
  input wire logic i_rd_ds_n,
  input wire logic i_wr_rw_n,
  input wire logic i_ale_as,
  input wire logic [LPP_AW-1:0] i_addr_pin,
  input wire logic [LPP_DW-1:0] i_data_pin,
  output logic [LPP_DW-1:0] o_data_pin,
  output logic o_data_oe,
  input wire logic i_hard_reset_n,
  input wire logic i_iface_sel_lo,
  input wire logic i_iface_sel_hi,
  input wire logic i_bus_flavour_select,
  output logic o_int_n_out,
  output logic o_int_oe,
  // internal software port
  input wire logic [LPP_AW-1:0] i_sw_addr,
  input wire logic [LPP_DW-1:0] i_sw_wdata,
  input wire logic i_sw_wr,
  input wire logic i_sw_rd,
  output logic [LPP_DW-1:0] o_sw_rdata
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NS = 9 + LPP_AW + LPP_DW;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  // two flip-flops on every pin before any logic reads it
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_q <= '1;
      s2_q <= '1;
    end
    else
    begin
      s1_q <= {i_cs_n, i_rd_ds_n, i_wr_rw_n, i_ale_as, i_hard_reset_n, i_iface_sel_lo,
               i_iface_sel_hi, i_bus_flavour_select, 1'b1, i_addr_pin, i_data_pin};
      s2_q <= s1_q;
    end
  end

  // ---------------------------------------------------------------
  // synchronised pin view
  // ---------------------------------------------------------------
  logic cs_n;
  logic rd_ds_n;
  logic wr_rw_n;
  logic ale_as;
  logic hard_reset_n_n;
  logic sel_lo;
  logic sel_hi;
  logic flv;
  logic [LPP_AW-1:0] apin;
  logic [LPP_DW-1:0] dpin;
  // unpack the second stage; nothing reads the first
  assign cs_n = s2_q[NS-1];    // chip select, low active
  assign rd_ds_n = s2_q[NS-2]; // read or data strobe
  assign wr_rw_n = s2_q[NS-3]; // write strobe or direction
  assign ale_as = s2_q[NS-4];  // address latch strobe
  assign hard_reset_n_n = s2_q[NS-5];  // hard reset, low active
  assign sel_lo = s2_q[NS-6];
  assign sel_hi = s2_q[NS-7];
  assign flv = s2_q[NS-8];
  assign apin = s2_q[LPP_AW+LPP_DW-1:LPP_DW];
  assign dpin = s2_q[LPP_DW-1:0];

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  function automatic lpp_flavour_t flavour(input logic f);
    return f ? LPP_FLV_DSTRB : LPP_FLV_SPLIT;
  endfunction
  logic par_en;
  logic muxed;
  // parallel port off while iface_sel_hi is high
  assign par_en = !sel_hi;
  assign muxed = par_en && !sel_lo;
  // software register decode, shared by the status and enable paths
  function automatic logic sw_hit(input logic [LPP_AW-1:0] ad, input logic [LPP_AW-1:0] off);
    return ad == off;
  endfunction
  logic clr_hit;
  logic en_hit;
  assign clr_hit = i_sw_wr && sw_hit(i_sw_addr, LPP_OFF_CLEAR);
  assign en_hit = i_sw_wr && sw_hit(i_sw_addr, LPP_OFF_IRQ_EN);

  // ---------------------------------------------------------------
  // edge history
  // ---------------------------------------------------------------
  // stage 2 pins hold previous values for edge detection
  logic cs_n_q;
  logic rd_ds_n_q;
  logic wr_rw_n_q;
  logic ale_as_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cs_n_q <= 1'b1;
      rd_ds_n_q <= 1'b1;
      wr_rw_n_q <= 1'b1;
      ale_as_q <= 1'b0;
    end
    else
    begin
      cs_n_q <= cs_n;
      rd_ds_n_q <= rd_ds_n;
      wr_rw_n_q <= wr_rw_n;
      ale_as_q <= ale_as;
    end
  end


  // ---------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------
  // strobe meaning per flavour
  logic rd_act;
  logic rd_act_q;
  logic wr_end;
  always_comb
  begin
    rd_act = 1'b0;
    wr_end = 1'b0;
    case (flavour(flv))
      LPP_FLV_SPLIT:
      begin
        rd_act = !rd_ds_n;
        wr_end = wr_rw_n && !wr_rw_n_q;
      end
      LPP_FLV_DSTRB:
      begin
        rd_act = !rd_ds_n && wr_rw_n;
        wr_end = rd_ds_n && !rd_ds_n_q && !wr_rw_n;
      end
      default:
      begin
        rd_act = 1'b0;
        wr_end = 1'b0;
      end
    endcase
  end
  assign rd_act_q = rd_act;

  // ---------------------------------------------------------------
  // select qualification
  // ---------------------------------------------------------------
  // select must stand two samples so a glitch on the pin is ignored
  logic sel;
  assign sel = par_en && !cs_n && !cs_n_q;

  // ---------------------------------------------------------------
  // address latch
  // ---------------------------------------------------------------
  logic [LPP_AW-1:0] alat_q;
  // address taken on the rising edge of the latch strobe
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      alat_q <= '0;
    else if (muxed && ale_as && !ale_as_q)
      alat_q <= dpin[LPP_AW-1:0];
  end

  // ---------------------------------------------------------------
  // address select
  // ---------------------------------------------------------------
  // latched address when multiplexed, dedicated pins otherwise
  logic [LPP_AW-1:0] haddr;
  assign haddr = muxed ? alat_q : apin;

  // ---------------------------------------------------------------
  // register memory and software access
  // ---------------------------------------------------------------
  lpp_mem_if mi ();
  lpp_regmem u_mem (
    .i_clk(i_clk),
    .i_rst(i_rst || !hard_reset_n_n),
    .m(mi)
  );
  logic host_wr;
  logic sw_wr_mem;
  // host wins the shared write and read ports over software
  assign host_wr = sel && wr_end;
  assign sw_wr_mem = i_sw_wr && (i_sw_addr < LPP_OFF_STATUS);
  assign mi.we = host_wr || sw_wr_mem;
  assign mi.waddr = host_wr ? haddr : i_sw_addr;
  assign mi.wdata = host_wr ? dpin : i_sw_wdata;
  assign mi.raddr = (sel && rd_act_q) ? haddr : i_sw_addr;

  // ---------------------------------------------------------------
  // events and interrupt
  // ---------------------------------------------------------------
  logic [LPP_NEV-1:0] ev;
  logic [LPP_NEV-1:0] stat_q;
  logic [LPP_NEV-1:0] en_q;
  logic rd_start;
  // a host read counts once, on the first cycle of the strobe, and only if selected in that cycle
  assign rd_start = sel && rd_act && !(rd_ds_n_q == 1'b0);
  // event vector
  always_comb
  begin
    ev = '0;
    ev[LPP_EV_HOST_WR] = host_wr;
    ev[LPP_EV_HOST_RD] = rd_start;
    ev[LPP_EV_SW_WR] = sw_wr_mem;
  end

  // ---------------------------------------------------------------
  // status and enable
  // ---------------------------------------------------------------
  // sticky status; an event in the clear cycle stays set
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      stat_q <= '0;
    else if (clr_hit)
      stat_q <= (stat_q & ~i_sw_wdata[LPP_NEV-1:0]) | ev; // set wins
    else
      stat_q <= stat_q | ev;
  end
  // enable mask, cleared by hard reset like the control bytes
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !hard_reset_n_n)
      en_q <= '0;
    else if (en_hit)
      en_q <= i_sw_wdata[LPP_NEV-1:0];
  end

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------
  // open drain: drive low only while an enabled event is pending
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_int_oe <= 1'b0;
    else
      o_int_oe <= |(stat_q & en_q);
  end
  assign o_int_n_out = 1'b0;

  // ---------------------------------------------------------------
  // read paths
  // ---------------------------------------------------------------
  logic sw_rd_q;
  logic [LPP_AW-1:0] sw_addr_q;
  // remember the software read for one cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sw_rd_q <= 1'b0;
      sw_addr_q <= '0;
    end
    else
    begin
      sw_rd_q <= i_sw_rd;
      sw_addr_q <= i_sw_addr;
    end
  end
  // software read data, the cycle after the strobe
  always_comb
  begin
    case (sw_addr_q)
      LPP_OFF_STATUS: o_sw_rdata = {{(LPP_DW-LPP_NEV){1'b0}}, stat_q};
      LPP_OFF_IRQ_EN: o_sw_rdata = {{(LPP_DW-LPP_NEV){1'b0}}, en_q};
      LPP_OFF_CLEAR: o_sw_rdata = 8'h00;
      default: o_sw_rdata = sw_rd_q ? mi.rdata : 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // host data pins
  // ---------------------------------------------------------------
  // host data pins driven only while selected and reading
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_data_oe <= 1'b0;
      o_data_pin <= 8'h00;
    end
    else
    begin
      o_data_oe <= sel && rd_act;
      o_data_pin <= mi.rdata;
    end
  end
endmodule
`default_nettype wire

// [lpp_host_port_chk.sv]
`default_nettype none
module lpp_host_port_chk
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_ds_n,
  input wire logic i_wr_rw_n,
  input wire logic i_iface_sel_hi,
  input wire logic i_hard_reset_n,
  input wire logic o_data_oe,
  input wire logic o_int_n_out,
  input wire logic o_int_oe
);
  logic [3:0] cs_age;
  logic [3:0] rd_age;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // cycles since select and read strobe were last low
  always_ff @(posedge i_clk)
  begin
    cs_age <= (i_rst || !i_cs_n) ? 4'h0 : cs_age + {3'h0, cs_age != 4'hF};
    rd_age <= (i_rst || !i_rd_ds_n) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hF};
  end
  a_drive_needs_cs: assert property (o_data_oe |-> cs_age < 4'h6)
    else $error("data driven while deselected");
  a_drive_needs_rd: assert property (o_data_oe |-> rd_age < 4'h6)
    else $error("data driven without read");
  a_read_drives_bus:
    assert property ((!i_cs_n && !i_rd_ds_n && i_wr_rw_n && !i_iface_sel_hi)[*6] |-> o_data_oe)
    else $error("read not answered");
  a_cs_high_idle: assert property (i_cs_n[*6] |-> !o_data_oe)
    else $error("bus driven while deselected");
  a_port_off_idle: assert property (i_iface_sel_hi[*6] |-> !o_data_oe)
    else $error("bus driven while port off");
  a_int_pulls_low: assert property (o_int_oe |-> !o_int_n_out)
    else $error("interrupt pin not low");
  a_hard_clears_irq: assert property (!i_hard_reset_n[*8] |-> !o_int_oe)
    else $error("interrupt kept in hard reset");
  a_reset_quiet:
    assert property (disable iff (1'b0) i_rst |=> !o_data_oe && !o_int_oe)
    else $error("outputs active after reset");
endmodule
bind lpp_host_port lpp_host_port_chk i_chk (.i_clk, .i_rst, .i_cs_n, .i_rd_ds_n,
  .i_wr_rw_n, .i_iface_sel_hi, .i_hard_reset_n, .o_data_oe, .o_int_n_out, .o_int_oe);
`default_nettype wire

// [lpp_host_model.sv]
`default_nettype none
module lpp_host_model
(
  input wire logic i_clk,
  input wire logic [7:0] i_bus,
  output logic o_cs_n = 1'b1,
  output logic o_rd_n = 1'b1,
  output logic o_wr_n = 1'b1,
  output logic o_ale = 1'b0,
  output logic [4:0] o_addr = 5'h00,
  output logic [7:0] o_d = 8'h00,
  output logic o_d_oe = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one host access; strobes held well beyond the sync depth
  task automatic acc(input bit mux, f, wr, sel, input logic [4:0] a,
    input logic [7:0] wd, output logic [7:0] rd);
    @(posedge i_clk);
    o_cs_n <= !sel;
    o_wr_n <= f ? !wr : 1'b1;
    o_addr <= mux ? 5'h00 : a;
    o_d <= {3'h0, a};
    o_d_oe <= mux;
    repeat (4) @(posedge i_clk);
    o_ale <= mux;
    repeat (4) @(posedge i_clk);
    o_ale <= 1'b0;
    o_d <= wd;
    o_d_oe <= wr;
    o_rd_n <= wr && !f;
    if (!f)
      o_wr_n <= !wr;
    repeat (8) @(posedge i_clk);
    rd = i_bus;
    o_rd_n <= 1'b1;
    if (!f)
      o_wr_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_d_oe <= 1'b0;
    repeat (5) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// [lineif_parallel_host_port_tb.sv]
`default_nettype none
module lineif_parallel_host_port_tb;
  import lpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst = 1, i_hard_reset_n = 1, i_iface_sel_lo = 1, i_iface_sel_hi = 0;
  logic i_bus_flavour_select = 0, i_sw_wr = 0, i_sw_rd = 0, h_oe, o_data_oe;
  logic cs_n, rd_n, wr_n, ale, o_int_n_out, o_int_oe;
  logic [4:0] addr, a, i_sw_addr = 0;
  logic [7:0] hd, o_data_pin, bus, bus_q = 0, i_sw_wdata = 0, o_sw_rdata, rv;
  logic [31:0] lf = 32'h4892B839;
  int num_errors = 0, compares = 0, cyc = 0;
  int mem [32];
  always #50 i_clk = ~i_clk;
  // shared data wire; stale value inverts every cycle
  assign bus = h_oe ? hd : o_data_oe ? o_data_pin : ~bus_q;
  always @(posedge i_clk) bus_q <= bus;
  lpp_host_model i_host (.i_clk, .i_bus(bus), .o_cs_n(cs_n), .o_rd_n(rd_n),
    .o_wr_n(wr_n), .o_ale(ale), .o_addr(addr), .o_d(hd), .o_d_oe(h_oe));
  lpp_host_port i_dut (.i_clk, .i_rst, .i_cs_n(cs_n), .i_rd_ds_n(rd_n), .i_wr_rw_n(wr_n),
    .i_ale_as(ale), .i_addr_pin(addr), .i_data_pin(bus), .o_data_pin, .o_data_oe,
    .i_hard_reset_n, .i_iface_sel_lo, .i_iface_sel_hi, .i_bus_flavour_select, .o_int_n_out,
    .o_int_oe, .i_sw_addr, .i_sw_wdata, .i_sw_wr, .i_sw_rd, .o_sw_rdata);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic swr(input logic [4:0] ad, input logic [7:0] d);
    @(posedge i_clk);
    i_sw_addr <= ad;
    i_sw_wdata <= d;
    i_sw_wr <= 1'b1;
    @(posedge i_clk);
    i_sw_wr <= 1'b0;
  endtask
  task automatic srd(input logic [4:0] ad);
    @(posedge i_clk);
    i_sw_addr <= ad;
    i_sw_rd <= 1'b1;
    @(posedge i_clk);
    i_sw_rd <= 1'b0;
    #1 rv = o_sw_rdata;
  endtask
  task automatic hacc(input bit mux, f, wr, sel, input logic [4:0] ad, input logic [7:0] d);
    i_iface_sel_lo <= !mux;
    i_bus_flavour_select <= f;
    i_host.acc(mux, f, wr, sel, ad, d, rv);
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    // every addressing mode and strobe flavour
    for (int m = 0; m < 4; m++)
    begin
      lf = nx(lf);
      a = 5'(lf[4:0] % 29);
      hacc(m[1], m[0], 1'b1, 1'b1, a, lf[15:8]);
      mem[a] = lf[15:8];
      hacc(m[1], m[0], 1'b0, 1'b1, a, 8'h00);
      chk("host read", rv, 8'(mem[a]));
      srd(a);
      chk("sw read", rv, 8'(mem[a]));
    end
    hacc(1'b0, 1'b0, 1'b1, 1'b0, a, ~lf[15:8]);
    i_iface_sel_hi <= 1'b1;
    hacc(1'b0, 1'b0, 1'b1, 1'b1, a, ~lf[15:8]);
    i_iface_sel_hi <= 1'b0;
    srd(a);
    chk("refused write", rv, 8'(mem[a]));
    swr(5'h05, 8'h3C);
    srd(LPP_OFF_STATUS);
    chk("status", rv, 8'h07);
    swr(LPP_OFF_CLEAR, 8'h07);
    srd(LPP_OFF_STATUS);
    chk("status cleared", rv, 8'h00);
    swr(LPP_OFF_IRQ_EN, 8'h01);
    #1 chk("irq idle", 8'(o_int_oe), 8'h00);
    hacc(1'b0, 1'b0, 1'b1, 1'b1, 5'h02, 8'h5A);
    #1 chk("irq raised", 8'(o_int_oe), 8'h01);
    swr(LPP_OFF_IRQ_EN, 8'h00);
    repeat (2) @(posedge i_clk);
    #1 chk("irq masked", 8'(o_int_oe), 8'h00);
    swr(LPP_OFF_IRQ_EN, 8'h01);
    i_hard_reset_n <= 1'b0;
    repeat (10) @(posedge i_clk);
    i_hard_reset_n <= 1'b1;
    #1 chk("irq hard reset", 8'(o_int_oe), 8'h00);
    srd(5'h02);
    chk("ctrl hard reset", rv, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
